// file: rtl/dpl_regs.sv
// Purpose: model-register bank for the dram power-ceiling domain
// Assumes: one read or write per cycle, answered on the next edge
// Notes: measurement and throttle engine sit outside; they feed increments in
`timescale 1ns/10ps
`include "dpl_defs.svh"

module dpl_regs #(
    parameter int unsigned REFRESH_CYCLES = `DPL_REFRESH_CYCLES,
    parameter logic [14:0] SPEC_POWER = 15'h0000,
    parameter logic [14:0] MIN_POWER = 15'h0000,
    parameter logic [14:0] MAX_POWER = 15'h0000,
    parameter logic [5:0] MAX_WINDOW = 6'h00
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register access
    input wire dpl_pkg::dpl_req_t req_i,
    output logic [63:0] rdata_o,
    output logic rvalid_o,
    // measurement and throttle engine
    input wire logic energy_valid_i,
    input wire logic [15:0] energy_inc_i,
    input wire logic below_req_state_i,
    input wire logic time_tick_i,
    // ceiling settings to the engine
    output dpl_pkg::dpl_ctrl_t ctrl_o,
    output logic ceiling_active_o,
    output logic [4:0] win_exp_o,
    output logic [1:0] win_frac_o
);
    import dpl_pkg::*;

    // ****************************************
    // control register
    // ****************************************
    logic [63:0] ctrl_reg, ctrl_next;
    logic wr_ctrl;
    logic wr_taken;

    assign wr_ctrl = req_i.wr && (req_i.idx == `DPL_IDX_CEILING_CTRL);
    // locked register drops the write entirely
    assign wr_taken = wr_ctrl && !ctrl_reg[`DPL_LOCK_BIT];

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_taken) begin
            ctrl_next = req_i.wdata & `DPL_CTRL_WMASK;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_reg <= `DPL_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // counters
    // ****************************************
    logic [31:0] energy_total;
    logic [31:0] throttle_total;
    logic throttle_inc;

    // only time spent below the requested state is counted
    assign throttle_inc = time_tick_i && below_req_state_i;

    dpl_accum #(
        .INTERVAL(REFRESH_CYCLES),
        .INC_W(16)
    ) u_energy (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .inc_valid_i(energy_valid_i),
        .inc_i(energy_inc_i),
        .clear_i(1'b0),
        .total_o(energy_total)
    );

    dpl_accum #(
        .INTERVAL(1),
        .INC_W(1)
    ) u_throttle (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .inc_valid_i(throttle_inc),
        .inc_i(1'b1),
        .clear_i(1'b0),
        .total_o(throttle_total)
    );

    // ****************************************
    // read path and engine outputs
    // ****************************************
    dpl_info_t info;
    logic [63:0] rdata_next;
    logic rvalid_next;
    dpl_ctrl_t ctrl_view;
    logic ceiling_next;

    assign info = '{max_window: MAX_WINDOW, max_power: MAX_POWER,
                    min_power: MIN_POWER, spec_power: SPEC_POWER};

    always_comb begin
        ctrl_view.limit = ctrl_next[`DPL_LIMIT_MSB:0];
        ctrl_view.enable = ctrl_next[`DPL_ENABLE_BIT];
        ctrl_view.window = ctrl_next[`DPL_WIN_MSB:`DPL_WIN_LSB];
        ctrl_view.lock = ctrl_next[`DPL_LOCK_BIT];
        ceiling_next = ctrl_next[`DPL_ENABLE_BIT];
    end

    always_comb begin
        rdata_next = 64'h0000_0000_0000_0000;
        rvalid_next = req_i.rd;
        if (req_i.rd) begin
            unique case (req_i.idx)
                `DPL_IDX_CEILING_CTRL: rdata_next = ctrl_reg;
                `DPL_IDX_ENERGY_TOTAL: rdata_next = {32'h0000_0000, energy_total};
                `DPL_IDX_RANGE_INFO: rdata_next = {10'h000, info.max_window,
                    1'b0, info.max_power,
                    1'b0, info.min_power,
                    1'b0, info.spec_power};
                `DPL_IDX_THROTTLE_TOTAL: rdata_next = {32'h0000_0000, throttle_total};
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
            rvalid_o <= 1'b0;
            ctrl_o <= '0;
            ceiling_active_o <= 1'b0;
            win_exp_o <= '0;
            win_frac_o <= '0;
        end else begin
            rdata_o <= rdata_next;
            rvalid_o <= rvalid_next;
            ctrl_o <= ctrl_view;
            ceiling_active_o <= ceiling_next;
            win_exp_o <= ctrl_next[`DPL_WIN_EXP_MSB:`DPL_WIN_LSB];
            win_frac_o <= ctrl_next[`DPL_WIN_MSB:`DPL_WIN_FRAC_LSB];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // control register itself
    lock_holds_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ctrl_reg[`DPL_LOCK_BIT] |=> $stable(ctrl_reg))
        else $error("locked ceiling register changed");

    reserved_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ctrl_reg & ~`DPL_CTRL_WMASK) == 64'h0000_0000_0000_0000)
        else $error("reserved ceiling bits not zero");

    write_lands_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_taken |=>
        ctrl_reg == ($past(req_i.wdata) & `DPL_CTRL_WMASK))
        else $error("unlocked write not stored");

    ro_write_drop_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.wr && req_i.idx != `DPL_IDX_CEILING_CTRL |=> $stable(ctrl_reg))
        else $error("write to read-only register changed control");

    // engine outputs follow the written word one edge later
    enable_out_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> ceiling_active_o == ($past(wr_taken)
        ? $past(req_i.wdata[`DPL_ENABLE_BIT]) : $past(ctrl_reg[`DPL_ENABLE_BIT])))
        else $error("enable output disagrees");

    limit_out_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> ctrl_o.limit == ($past(wr_taken)
        ? $past(req_i.wdata[`DPL_LIMIT_MSB:0]) : $past(ctrl_reg[`DPL_LIMIT_MSB:0])))
        else $error("limit output disagrees");

    window_out_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> {win_frac_o, win_exp_o} == ($past(wr_taken)
        ? $past(req_i.wdata[`DPL_WIN_MSB:`DPL_WIN_LSB])
        : $past(ctrl_reg[`DPL_WIN_MSB:`DPL_WIN_LSB])))
        else $error("window fields disagree");

    // read path
    rvalid_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> rvalid_o == $past(req_i.rd))
        else $error("read valid not one cycle after request");

    rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !rvalid_o |-> rdata_o == 64'h0000_0000_0000_0000)
        else $error("read data not zero while idle");

    ctrl_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.rd && req_i.idx == `DPL_IDX_CEILING_CTRL |=> rdata_o == $past(ctrl_reg))
        else $error("control read wrong");

    info_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.rd && req_i.idx == `DPL_IDX_RANGE_INFO |=>
        rvalid_o && rdata_o[53:48] == MAX_WINDOW && rdata_o[14:0] == SPEC_POWER)
        else $error("info read wrong");

    info_limits_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.rd && req_i.idx == `DPL_IDX_RANGE_INFO |=>
        rdata_o[30:16] == MIN_POWER && rdata_o[46:32] == MAX_POWER)
        else $error("info power limits wrong");

    energy_hi_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.rd && req_i.idx == `DPL_IDX_ENERGY_TOTAL |=>
        rdata_o == {32'h0000_0000, $past(energy_total)})
        else $error("energy read wrong");

    throttle_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_i.rd && req_i.idx == `DPL_IDX_THROTTLE_TOTAL |=>
        rdata_o == {32'h0000_0000, $past(throttle_total)})
        else $error("throttle read wrong");

    // throttle counting
    throttle_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !throttle_inc ##1 !throttle_inc |=> $stable(throttle_total))
        else $error("throttle counted while not throttled");

    throttle_step_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> throttle_total - $past(throttle_total) <= 32'h0000_0001)
        else $error("throttle total stepped by more than one");

endmodule : dpl_regs

// file: inc/dpl_defs.svh
// Purpose: offsets, field positions, reset values and timing counts for the dram power-ceiling bank
// Assumes: 64-bit register data, one register selected per access by index
// Notes: register indices are local selectors
`ifndef DPL_DEFS_SVH
`define DPL_DEFS_SVH

// ****************************************
// register selectors
// ****************************************
`define DPL_IDX_CEILING_CTRL 2'h0
`define DPL_IDX_ENERGY_TOTAL 2'h1
`define DPL_IDX_RANGE_INFO 2'h2
`define DPL_IDX_THROTTLE_TOTAL 2'h3

// ****************************************
// field positions
// ****************************************
`define DPL_LIMIT_MSB 14
`define DPL_ENABLE_BIT 15
`define DPL_WIN_LSB 17
`define DPL_WIN_MSB 23
`define DPL_WIN_EXP_MSB 21
`define DPL_WIN_FRAC_LSB 22
`define DPL_LOCK_BIT 31
`define DPL_CTRL_WMASK 64'h0000_0000_80FE_FFFF
`define DPL_CTRL_RESET 64'h0000_0000_0000_0000

// ****************************************
// timing
// ****************************************
`define DPL_REFRESH_US 1000
`define DPL_CLK_MHZ 200
`define DPL_REFRESH_CYCLES (`DPL_REFRESH_US * `DPL_CLK_MHZ)

`endif

// file: inc/dpl_pkg.sv
// Purpose: shared types for the dram power-ceiling bank
// Assumes: nothing beyond the defs header
// Notes: field layout mirrors the power-ceiling control register
package dpl_pkg;

    typedef struct packed {
        logic lock;
        logic [6:0] window;
        logic enable;
        logic [14:0] limit;
    } dpl_ctrl_t;

    typedef struct packed {
        logic [5:0] max_window;
        logic [14:0] max_power;
        logic [14:0] min_power;
        logic [14:0] spec_power;
    } dpl_info_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] idx;
        logic [63:0] wdata;
    } dpl_req_t;

endpackage : dpl_pkg

// file: rtl/dpl_accum.sv
// Purpose: 32-bit accumulator refreshed once per interval
// Assumes: increments come from logic on the same clock
// Notes: wraps silently, as the counters are free-running totals
`timescale 1ns/10ps

module dpl_accum #(
    parameter int unsigned INTERVAL = 1,
    parameter int unsigned INC_W = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // increments and clear
    input wire logic inc_valid_i,
    input wire logic [INC_W-1:0] inc_i,
    input wire logic clear_i,
    // total
    output logic [31:0] total_o
);
    localparam int unsigned CW = (INTERVAL > 1) ? $clog2(INTERVAL) : 1;

    logic [31:0] pend_reg, pend_next;
    logic [31:0] total_reg, total_next;
    logic [CW-1:0] tick_reg, tick_next;
    logic tick_hit;

    assign tick_hit = (tick_reg == CW'(INTERVAL - 1));

    always_comb begin
        tick_next = tick_hit ? '0 : tick_reg + CW'(1);
        pend_next = pend_reg;
        total_next = total_reg;
        if (tick_hit) begin
            // pending sum lands in the visible total only at the interval edge
            total_next = total_reg + pend_reg;
            pend_next = '0;
        end
        if (inc_valid_i) begin
            pend_next = pend_next + 32'(inc_i);
        end
        if (clear_i) begin
            total_next = '0;
            pend_next = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tick_reg <= '0;
            pend_reg <= '0;
            total_reg <= '0;
        end else begin
            tick_reg <= tick_next;
            pend_reg <= pend_next;
            total_reg <= total_next;
        end
    end

    assign total_o = total_reg;

    // ****************************************
    // checks
    // ****************************************
    // visible total only moves at the interval edge or on clear
    total_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !tick_hit && !clear_i |=> $stable(total_reg))
        else $error("total moved between interval edges");

    tick_range_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        tick_reg <= CW'(INTERVAL - 1))
        else $error("interval counter out of range");

endmodule : dpl_accum

// file: verification/dram_power_limit_regs_tb_top.sv
// Purpose: self-checking bench for the dram power-ceiling register bank
// Assumes: short refresh interval in sim; bench drives all ports at falling edge
// Notes: expected values built from field layout, not from design outputs
`timescale 1ns/10ps
`include "dpl_defs.svh"

module dram_power_limit_regs_tb_top;
    import dpl_pkg::*;
    localparam int unsigned REFRESH = 20;
    localparam logic [14:0] SPEC_P = 15'h1234;
    localparam logic [14:0] MIN_P = 15'h0456;
    localparam logic [14:0] MAX_P = 15'h7abc;
    localparam logic [5:0] MAX_W = 6'h2d;
    logic core_clk_i, reset_i, rvalid_o, energy_valid_i, below_req_state_i, time_tick_i;
    logic ceiling_active_o;
    logic [15:0] energy_inc_i;
    logic [63:0] rdata_o, d, w, exp_ctrl;
    logic [4:0] win_exp_o;
    logic [1:0] win_frac_o;
    logic [31:0] exp_energy, exp_thr;
    dpl_req_t req_i;
    dpl_ctrl_t ctrl_o;
    int n_errors, comparisons;

    dpl_regs #(.REFRESH_CYCLES(REFRESH), .SPEC_POWER(SPEC_P), .MIN_POWER(MIN_P),
        .MAX_POWER(MAX_P), .MAX_WINDOW(MAX_W)) dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .energy_valid_i(energy_valid_i), .energy_inc_i(energy_inc_i),
        .below_req_state_i(below_req_state_i), .time_tick_i(time_tick_i), .ctrl_o(ctrl_o),
        .ceiling_active_o(ceiling_active_o), .win_exp_o(win_exp_o), .win_frac_o(win_frac_o));

    // ****************************************
    // clock, helpers
    // ****************************************
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [63:0] info_exp();
        return {10'h000, MAX_W, 1'b0, MAX_P, 1'b0, MIN_P, 1'b0, SPEC_P};
    endfunction : info_exp

    // software-side word: window kept within the reported maximum
    function automatic logic [63:0] sw_word(input logic lock_v);
        logic [63:0] v;
        v = {$urandom, $urandom};
        v[`DPL_WIN_MSB:`DPL_WIN_LSB] = 7'($urandom_range(MAX_W, 0));
        v[`DPL_LOCK_BIT] = lock_v;
        return v;
    endfunction : sw_word

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_ctrl(input logic [63:0] e);
        chk("ctrl_o", {40'h0, e[31], e[23:17], e[15], e[14:0]}, {40'h0, ctrl_o});
        chk("enable", {63'h0, e[15]}, {63'h0, ceiling_active_o});
        chk("window", {57'h0, e[23:22], e[21:17]}, {57'h0, win_frac_o, win_exp_o});
    endtask : chk_ctrl

    task automatic rd(input logic [1:0] idx);
        @(negedge core_clk_i);
        req_i = '{rd: 1'b1, wr: 1'b0, idx: idx, wdata: 64'h0};
        @(negedge core_clk_i);
        req_i.rd = 1'b0;
        chk("rvalid_o", 64'h1, {63'h0, rvalid_o});
        d = rdata_o;
    endtask : rd

    task automatic wr(input logic [1:0] idx, input logic [63:0] data);
        @(negedge core_clk_i);
        req_i = '{rd: 1'b0, wr: 1'b1, idx: idx, wdata: data};
        @(negedge core_clk_i);
        req_i.wr = 1'b0;
    endtask : wr

    task automatic do_reset();
        reset_i = 1'b1;
        repeat (20) @(negedge core_clk_i);
        reset_i = 1'b0;
    endtask : do_reset

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    // ****************************************
    // tests
    // ****************************************
    initial begin
        #25000;
        n_errors++;
        complete_run();
    end

    initial begin
        req_i = '0;
        {energy_valid_i, energy_inc_i, below_req_state_i, time_tick_i} = '0;
        void'($urandom(32'hdb70_11b1));
        do_reset();
        rd(`DPL_IDX_CEILING_CTRL);
        chk("ctrl rst", `DPL_CTRL_RESET, d);
        rd(`DPL_IDX_ENERGY_TOTAL);
        chk("energy rst", 64'h0, d);
        rd(`DPL_IDX_RANGE_INFO);
        chk("info", info_exp(), d);
        rd(`DPL_IDX_THROTTLE_TOTAL);
        chk("thr rst", 64'h0, d);
        $display("test reset values done");
        // first pass all ones bar the lock bit and a legal window: undefined bits must drop
        for (int i = 0; i < 16; i++) begin
            w = (i == 0) ? (64'hFFFF_FFFF_7F01_FFFF | {40'h0, 1'b0, MAX_W, 17'h0})
                : sw_word(1'b0);
            wr(`DPL_IDX_CEILING_CTRL, w);
            exp_ctrl = w & `DPL_CTRL_WMASK;
            chk_ctrl(exp_ctrl);
            rd(`DPL_IDX_CEILING_CTRL);
            chk("ctrl rd", exp_ctrl, d);
            wr(2'($urandom_range(3, 1)), {$urandom, $urandom});
            rd(`DPL_IDX_RANGE_INFO);
            chk("info ro", info_exp(), d);
            rd(`DPL_IDX_ENERGY_TOTAL);
            chk("energy ro", 64'h0, d);
            rd(`DPL_IDX_THROTTLE_TOTAL);
            chk("thr ro", 64'h0, d);
        end
        $display("test control writes done");
        w = sw_word(1'b1);
        wr(`DPL_IDX_CEILING_CTRL, w);
        exp_ctrl = w & `DPL_CTRL_WMASK;
        repeat (6) begin
            wr(`DPL_IDX_CEILING_CTRL, sw_word(1'b0));
            chk_ctrl(exp_ctrl);
            rd(`DPL_IDX_CEILING_CTRL);
            chk("locked", exp_ctrl, d);
        end
        $display("test lock done");
        exp_energy = '0;
        repeat (60) begin
            @(negedge core_clk_i);
            energy_valid_i = 1'($urandom);
            energy_inc_i = 16'($urandom);
            if (energy_valid_i) exp_energy += 32'(energy_inc_i);
        end
        @(negedge core_clk_i);
        energy_valid_i = 1'b0;
        repeat (2 * REFRESH + 2) @(negedge core_clk_i);
        rd(`DPL_IDX_ENERGY_TOTAL);
        chk("energy", {32'h0, exp_energy}, d);
        $display("test energy done");
        exp_thr = '0;
        repeat (80) begin
            @(negedge core_clk_i);
            time_tick_i = 1'($urandom);
            below_req_state_i = 1'($urandom);
            if (time_tick_i && below_req_state_i) exp_thr++;
        end
        @(negedge core_clk_i);
        time_tick_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rd(`DPL_IDX_THROTTLE_TOTAL);
        chk("throttle", {32'h0, exp_thr}, d);
        $display("test throttle done");
        do_reset();
        chk_ctrl(`DPL_CTRL_RESET);
        rd(`DPL_IDX_ENERGY_TOTAL);
        chk("energy clr", 64'h0, d);
        rd(`DPL_IDX_THROTTLE_TOTAL);
        chk("thr clr", 64'h0, d);
        w = sw_word(1'($urandom));
        wr(`DPL_IDX_CEILING_CTRL, w);
        rd(`DPL_IDX_CEILING_CTRL);
        chk("unlocked", w & `DPL_CTRL_WMASK, d);
        $display("test reset unlock done");
        complete_run();
    end
endmodule : dram_power_limit_regs_tb_top
